// >>> common/cr_params.svh
// Constants for the cold redundancy role control block
`ifndef CR_PARAMS_SVH
`define CR_PARAMS_SVH

// Register byte offsets on the APB
`define REG_PIN_CMD          12'h000
`define REG_ROLE             12'h004
`define REG_STATUS           12'h008
`define REG_ENERGY_ACC       12'h00C
`define REG_ENERGY_CNT       12'h010

// Pin command field positions (code, first byte, second byte)
`define PINCMD_CODE_LSB      16
`define PINCMD_FIRST_LSB     8
`define PINCMD_SECOND_LSB    0

// Status register bit positions
`define ST_PIN_MODE          0
`define ST_BUS_LEVEL         1
`define ST_MAIN_ON           2
`define ST_CR_ARMED          3
`define ST_STANDBY           4
`define ST_POWER_GOOD        5
`define ST_INPUT_OK          6

// Management command codes and data bytes
`define CMD_PIN_MODE         8'hEA
`define SEQ_BYTE_A           8'h69
`define SEQ_BYTE_B           8'h96

// Role bytes
`define ROLE_BYTE_CONV       8'h00
`define ROLE_BYTE_ALWAYS_ON  8'h01
`define ROLE_BYTE_STANDBY_1  8'h02
`define ROLE_BYTE_STANDBY_2  8'h03
`define ROLE_BYTE_STANDBY_3  8'h04

// Share thresholds in units of 10 mA
`define THR_ON_1             16'h1A0B
`define THR_OFF_1            16'h0BB8
`define THR_ON_2             16'h285D
`define THR_OFF_2            16'h1856
`define THR_ON_3             16'h36B0
`define THR_OFF_3            16'h24F4

// Timing
`define CLK_FREQ_MHZ         125
`define PRE_WARN_TIME_US     1000
`define PRE_WARN_CYCLES      (`PRE_WARN_TIME_US * `CLK_FREQ_MHZ)
`define RAPID_ON_TIME_US     100
`define RAPID_ON_CYCLES      (`RAPID_ON_TIME_US * `CLK_FREQ_MHZ)

`endif

// >>> common/cr_pkg.sv
// Types shared by the cold redundancy role control block
package cr_pkg;

    typedef enum logic {
        PIN_INPUT_GOOD,
        PIN_RAPID_BUS
    } pin_mode_t;

    typedef enum logic [2:0] {
        ROLE_CONVENTIONAL,
        ROLE_ALWAYS_ON,
        ROLE_STANDBY_1,
        ROLE_STANDBY_2,
        ROLE_STANDBY_3
    } role_t;

    typedef enum logic {
        CR_IDLE,
        CR_ARMED
    } cr_state_t;

endpackage

// >>> core/cold_redundancy_role_control.sv
// Dual function pin and cold redundancy role control with APB registers
`include "cr_params.svh"
`timescale 1ns/10ps
`default_nettype none

module cold_redundancy_role_control #(
    parameter int unsigned PRE_WARN_CYCLES = `PRE_WARN_CYCLES
) (
    // APB slave
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Dual function pin
    input  wire logic        dual_function_pin_in,
    output logic             dual_function_pin_out,
    output logic             dual_function_pin_oe_n,
    output logic             redundancy_bus_pullup_en,
    // Supply state
    input  wire logic        input_power_ok,
    input  wire logic        fault_in,
    input  wire logic        warning_in,
    input  wire logic [15:0] current_share_bus,
    input  wire logic        stored_rapid_bus_mode,
    output logic             stored_mode_out,
    output logic             power_good,
    output logic             main_output_on,
    output logic             fault_report,
    output logic             warning_report,
    // Energy samples
    input  wire logic        sample_strobe,
    input  wire logic [15:0] input_power_sample
);

    localparam logic [16:0] WARN_LIMIT = 17'(PRE_WARN_CYCLES);
    localparam logic [13:0] RAPID_LIMIT = 14'(`RAPID_ON_CYCLES);

    // Role byte decode, shared by the write path and checks
    function automatic logic role_valid(input logic [7:0] b);
        return (b == `ROLE_BYTE_CONV) || (b == `ROLE_BYTE_ALWAYS_ON) ||
               (b == `ROLE_BYTE_STANDBY_1) || (b == `ROLE_BYTE_STANDBY_2) ||
               (b == `ROLE_BYTE_STANDBY_3);
    endfunction

    function automatic cr_pkg::role_t role_of(input logic [7:0] b);
        case (b)
            `ROLE_BYTE_ALWAYS_ON: return cr_pkg::ROLE_ALWAYS_ON;
            `ROLE_BYTE_STANDBY_1: return cr_pkg::ROLE_STANDBY_1;
            `ROLE_BYTE_STANDBY_2: return cr_pkg::ROLE_STANDBY_2;
            `ROLE_BYTE_STANDBY_3: return cr_pkg::ROLE_STANDBY_3;
            default:              return cr_pkg::ROLE_CONVENTIONAL;
        endcase
    endfunction

    function automatic logic is_standby(input cr_pkg::role_t r);
        return (r == cr_pkg::ROLE_STANDBY_1) ||
               (r == cr_pkg::ROLE_STANDBY_2) ||
               (r == cr_pkg::ROLE_STANDBY_3);
    endfunction

    function automatic logic addr_mapped(input logic [11:0] a);
        return (a == `REG_PIN_CMD) || (a == `REG_ROLE) ||
               (a == `REG_STATUS) || (a == `REG_ENERGY_ACC) ||
               (a == `REG_ENERGY_CNT);
    endfunction

    // Registers and state
    logic [1:0]         meta_ff;
    logic [1:0]         sync_ff;
    logic               loaded_ff;
    cr_pkg::pin_mode_t  mode_ff;
    cr_pkg::role_t      role_ff;
    cr_pkg::cr_state_t  cr_ff;
    cr_pkg::cr_state_t  nxt_cr;
    logic [16:0]        loss_cnt_ff;
    logic               power_good_ff;
    logic               main_on_ff;
    logic               nxt_main_on;
    logic               pin_out_ff;
    logic               pin_oe_n_ff;
    logic               pullup_ff;
    logic               fault_rep_ff;
    logic               warn_rep_ff;
    logic [31:0]        energy_acc_ff;
    logic [31:0]        energy_cnt_ff;
    logic [31:0]        prdata_ff;
    logic [31:0]        nxt_rdata;

    // Decoded signals
    logic        input_ok_s;
    logic        bus_level_s;
    logic        bus_low;
    logic        wr_en;
    logic        pin_cmd_wr;
    logic [7:0]  cmd_code;
    logic [7:0]  cmd_first;
    logic [7:0]  cmd_second;
    logic        to_input_good;
    logic        to_rapid_bus;
    logic        role_wr;
    logic        share_on;
    logic        standby_now;
    logic [15:0] thr_on;
    logic [15:0] thr_off;

    // Two flop synchronisers for the input sense and the bus pin
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_ff <= 2'h0;
            sync_ff <= 2'h0;
        end else begin
            meta_ff <= {dual_function_pin_in, input_power_ok};
            sync_ff <= meta_ff;
        end
    end

    assign input_ok_s  = sync_ff[0];
    assign bus_level_s = sync_ff[1];
    assign bus_low     = (mode_ff == cr_pkg::PIN_RAPID_BUS) && !bus_level_s;

    // APB decode, zero wait state
    assign pready     = 1'b1;
    assign pslverr    = psel && penable && !addr_mapped(paddr);
    assign wr_en      = psel && penable && pwrite && addr_mapped(paddr);
    assign pin_cmd_wr = wr_en && (paddr == `REG_PIN_CMD);
    assign cmd_code   = pwdata[`PINCMD_CODE_LSB +: 8];
    assign cmd_first  = pwdata[`PINCMD_FIRST_LSB +: 8];
    assign cmd_second = pwdata[`PINCMD_SECOND_LSB +: 8];

    // Only the two exact sequences change the pin mode
    assign to_input_good = pin_cmd_wr && (cmd_code == `CMD_PIN_MODE) &&
        (cmd_first == `SEQ_BYTE_A) && (cmd_second == `SEQ_BYTE_B);
    assign to_rapid_bus  = pin_cmd_wr && (cmd_code == `CMD_PIN_MODE) &&
        (cmd_first == `SEQ_BYTE_B) && (cmd_second == `SEQ_BYTE_A);

    // Pin mode: stored setting taken once after reset, then commands only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            loaded_ff <= 1'b0;
            mode_ff   <= cr_pkg::PIN_INPUT_GOOD;
        end else if (!loaded_ff) begin
            loaded_ff <= 1'b1;
            mode_ff   <= stored_rapid_bus_mode ? cr_pkg::PIN_RAPID_BUS
                                               : cr_pkg::PIN_INPUT_GOOD;
        end else if (to_input_good) begin
            mode_ff <= cr_pkg::PIN_INPUT_GOOD;
        end else if (to_rapid_bus) begin
            mode_ff <= cr_pkg::PIN_RAPID_BUS;
        end
    end

    // Mode is independent of input power, the store keeps it
    assign stored_mode_out = (mode_ff == cr_pkg::PIN_RAPID_BUS);

    // Role writes: valid byte and no cold redundancy in progress
    assign role_wr = wr_en && (paddr == `REG_ROLE) &&
                     role_valid(pwdata[7:0]) &&
                     (cr_ff == cr_pkg::CR_IDLE);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            role_ff <= cr_pkg::ROLE_CONVENTIONAL;
        end else if (role_wr) begin
            role_ff <= role_of(pwdata[7:0]);
        end
    end

    // Cold redundancy state: armed by a role write, ended by bus low or by leaving the bus mode
    always_comb begin
        nxt_cr = cr_ff;
        case (cr_ff)
            cr_pkg::CR_IDLE: begin
                if (role_wr && (pwdata[7:0] != `ROLE_BYTE_CONV) &&
                    (mode_ff == cr_pkg::PIN_RAPID_BUS) && !bus_low) begin
                    nxt_cr = cr_pkg::CR_ARMED;
                end
            end
            cr_pkg::CR_ARMED: begin
                if (bus_low || (mode_ff != cr_pkg::PIN_RAPID_BUS)) begin
                    nxt_cr = cr_pkg::CR_IDLE;
                end
            end
            default: nxt_cr = cr_pkg::CR_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cr_ff <= cr_pkg::CR_IDLE;
        end else begin
            cr_ff <= nxt_cr;
        end
    end

    // Threshold pair for the standby level
    always_comb begin
        case (role_ff)
            cr_pkg::ROLE_STANDBY_1: begin
                thr_on  = `THR_ON_1;
                thr_off = `THR_OFF_1;
            end
            cr_pkg::ROLE_STANDBY_2: begin
                thr_on  = `THR_ON_2;
                thr_off = `THR_OFF_2;
            end
            default: begin
                thr_on  = `THR_ON_3;
                thr_off = `THR_OFF_3;
            end
        endcase
    end

    // Share level comparison, direction dependent
    share_hysteresis u_share (
        .pclk          (pclk),
        .presetn       (presetn),
        .enable        ((cr_ff == cr_pkg::CR_ARMED) && is_standby(role_ff)),
        .share_level   (current_share_bus),
        .on_threshold  (thr_on),
        .off_threshold (thr_off),
        .want_on       (share_on)
    );

    // Output on/off decision
    always_comb begin
        nxt_main_on = 1'b1;
        if (is_standby(role_ff) && (cr_ff == cr_pkg::CR_ARMED) &&
            !bus_low) begin
            nxt_main_on = share_on;
        end
    end

    assign standby_now = is_standby(role_ff) && (cr_ff == cr_pkg::CR_ARMED) &&
                         !bus_low && !share_on;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            main_on_ff <= 1'b0;
        end else begin
            main_on_ff <= nxt_main_on;
        end
    end

    // Power good drops only after the pre-warning interval of input loss
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            loss_cnt_ff   <= 17'h00000;
            power_good_ff <= 1'b0;
        end else if (input_ok_s) begin
            loss_cnt_ff   <= 17'h00000;
            power_good_ff <= 1'b1;
        end else if (loss_cnt_ff >= WARN_LIMIT) begin
            power_good_ff <= 1'b0;
        end else begin
            loss_cnt_ff <= loss_cnt_ff + 17'h00001;
        end
    end

    // Pin drive: push-pull status, or open drain bus pulled on faults only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_out_ff  <= 1'b0;
            pin_oe_n_ff <= 1'b0;
            pullup_ff   <= 1'b0;
        end else if (mode_ff == cr_pkg::PIN_INPUT_GOOD) begin
            pin_out_ff  <= input_ok_s;
            pin_oe_n_ff <= 1'b0;
            pullup_ff   <= 1'b0;
        end else begin
            pin_out_ff  <= 1'b0;
            pin_oe_n_ff <= !fault_in;
            pullup_ff   <= (role_ff == cr_pkg::ROLE_ALWAYS_ON);
        end
    end

    // Status reports are hidden while in cold standby
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fault_rep_ff <= 1'b0;
            warn_rep_ff  <= 1'b0;
        end else begin
            fault_rep_ff <= fault_in && !standby_now;
            warn_rep_ff  <= warning_in && !standby_now;
        end
    end

    // Energy accumulator runs in every state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            energy_acc_ff <= 32'h00000000;
            energy_cnt_ff <= 32'h00000000;
        end else if (sample_strobe) begin
            energy_acc_ff <= energy_acc_ff + {16'h0000, input_power_sample};
            energy_cnt_ff <= energy_cnt_ff + 32'h00000001;
        end
    end

    // Read mux, captured in the setup phase
    always_comb begin
        nxt_rdata = 32'h00000000;
        case (paddr)
            `REG_PIN_CMD:    nxt_rdata[0] = stored_mode_out;
            `REG_ROLE:       nxt_rdata[2:0] = role_ff;
            `REG_STATUS: begin
                nxt_rdata[`ST_PIN_MODE]   = stored_mode_out;
                nxt_rdata[`ST_BUS_LEVEL]  = bus_level_s;
                nxt_rdata[`ST_MAIN_ON]    = main_on_ff;
                nxt_rdata[`ST_CR_ARMED]   = (cr_ff == cr_pkg::CR_ARMED);
                nxt_rdata[`ST_STANDBY]    = standby_now;
                nxt_rdata[`ST_POWER_GOOD] = power_good_ff;
                nxt_rdata[`ST_INPUT_OK]   = input_ok_s;
            end
            `REG_ENERGY_ACC: nxt_rdata = energy_acc_ff;
            `REG_ENERGY_CNT: nxt_rdata = energy_cnt_ff;
            default:         nxt_rdata = 32'h00000000;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= 32'h00000000;
        end else if (psel && !penable && !pwrite) begin
            prdata_ff <= nxt_rdata;
        end
    end

    // Output assignments
    assign prdata                   = prdata_ff;
    assign dual_function_pin_out    = pin_out_ff;
    assign dual_function_pin_oe_n   = pin_oe_n_ff;
    assign redundancy_bus_pullup_en = pullup_ff;
    assign power_good               = power_good_ff;
    assign main_output_on           = main_on_ff;
    assign fault_report             = fault_rep_ff;
    assign warning_report           = warn_rep_ff;

    // Cycles spent with the bus low and the output still off
    logic [13:0] rapid_cnt_ff;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rapid_cnt_ff <= 14'h0000;
        end else if (bus_low && !main_on_ff) begin
            rapid_cnt_ff <= rapid_cnt_ff + 14'h0001;
        end else begin
            rapid_cnt_ff <= 14'h0000;
        end
    end

    // Checks
    property p_pin_low_on_loss;
        @(posedge pclk) disable iff (!presetn)
        (loaded_ff && mode_ff == cr_pkg::PIN_INPUT_GOOD && !input_ok_s &&
         $stable(mode_ff)) |=> !dual_function_pin_out;
    endproperty
    a_pin_low_on_loss: assert property (p_pin_low_on_loss)
        else $error("pin not low after input loss");

    property p_prewarn;
        @(posedge pclk) disable iff (!presetn)
        $fell(power_good) |-> (loss_cnt_ff >= WARN_LIMIT) && !input_ok_s;
    endproperty
    a_prewarn: assert property (p_prewarn)
        else $error("power_good fell before pre-warning time");

    property p_pullup_master;
        @(posedge pclk) disable iff (!presetn)
        redundancy_bus_pullup_en |->
            $past(role_ff) == cr_pkg::ROLE_ALWAYS_ON &&
            $past(mode_ff) == cr_pkg::PIN_RAPID_BUS;
    endproperty
    a_pullup_master: assert property (p_pullup_master)
        else $error("pull-up enabled by a unit that is not always-on");

    property p_fault_pulls;
        @(posedge pclk) disable iff (!presetn)
        (mode_ff == cr_pkg::PIN_RAPID_BUS && fault_in) |=>
            (!dual_function_pin_oe_n && !dual_function_pin_out);
    endproperty
    a_fault_pulls: assert property (p_fault_pulls)
        else $error("fault did not pull the bus low");

    property p_rapid_on;
        @(posedge pclk) disable iff (!presetn)
        rapid_cnt_ff < RAPID_LIMIT && (rapid_cnt_ff < 14'h0003);
    endproperty
    a_rapid_on: assert property (p_rapid_on)
        else $error("output not on soon after bus low");

    property p_to_input_good;
        @(posedge pclk) disable iff (!presetn)
        (loaded_ff && to_input_good) |=>
            mode_ff == cr_pkg::PIN_INPUT_GOOD ##1
            !dual_function_pin_oe_n;
    endproperty
    a_to_input_good: assert property (p_to_input_good)
        else $error("pin mode did not return to input-good");

    property p_to_bus;
        @(posedge pclk) disable iff (!presetn)
        (loaded_ff && to_rapid_bus) |=> mode_ff == cr_pkg::PIN_RAPID_BUS;
    endproperty
    a_to_bus: assert property (p_to_bus)
        else $error("pin mode did not switch to the bus");

    property p_bad_cmd;
        @(posedge pclk) disable iff (!presetn)
        (loaded_ff && pin_cmd_wr && !to_input_good && !to_rapid_bus) |=>
            $stable(mode_ff);
    endproperty
    a_bad_cmd: assert property (p_bad_cmd)
        else $error("unmatched pin command changed the mode");

    property p_warning_free;
        @(posedge pclk) disable iff (!presetn)
        (mode_ff == cr_pkg::PIN_RAPID_BUS && $stable(mode_ff) &&
         !fault_in) |=> dual_function_pin_oe_n;
    endproperty
    a_warning_free: assert property (p_warning_free)
        else $error("bus pulled low without a fault");

    property p_bad_role;
        @(posedge pclk) disable iff (!presetn)
        (wr_en && paddr == `REG_ROLE && !role_valid(pwdata[7:0])) |=>
            $stable(role_ff);
    endproperty
    a_bad_role: assert property (p_bad_role)
        else $error("undefined role byte changed the role");

    property p_conv_on;
        @(posedge pclk) disable iff (!presetn)
        (loaded_ff && role_ff == cr_pkg::ROLE_CONVENTIONAL) ##1
        (role_ff == cr_pkg::ROLE_CONVENTIONAL) |-> main_output_on;
    endproperty
    a_conv_on: assert property (p_conv_on)
        else $error("conventional unit output off");

    c_enter_bus: cover property (@(posedge pclk) disable iff (!presetn)
        to_rapid_bus ##1 mode_ff == cr_pkg::PIN_RAPID_BUS);
    c_standby: cover property (@(posedge pclk) disable iff (!presetn)
        standby_now ##[1:20] !standby_now);
    c_rapid_wake: cover property (@(posedge pclk) disable iff (!presetn)
        (cr_ff == cr_pkg::CR_ARMED && !main_on_ff) ##1 bus_low);

endmodule

`default_nettype wire

// >>> core/share_hysteresis.sv
// Share level comparator with separate on and off thresholds
`timescale 1ns/10ps
`default_nettype none

module share_hysteresis (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // Control and levels
    input  wire logic        enable,
    input  wire logic [15:0] share_level,
    input  wire logic [15:0] on_threshold,
    input  wire logic [15:0] off_threshold,
    // Decision
    output logic             want_on
);

    logic want_on_ff;
    logic nxt_want_on;

    // Direction dependent threshold: rise at on, fall below off
    always_comb begin
        nxt_want_on = want_on_ff;
        if (!enable) begin
            nxt_want_on = 1'b0;
        end else if (!want_on_ff && share_level >= on_threshold) begin
            nxt_want_on = 1'b1;
        end else if (want_on_ff && share_level < off_threshold) begin
            nxt_want_on = 1'b0;
        end
    end

    // Decision register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            want_on_ff <= 1'b0;
        end else begin
            want_on_ff <= nxt_want_on;
        end
    end

    assign want_on = want_on_ff;

endmodule

`default_nettype wire

// >>> tb/cold_redundancy_role_control_tb.sv
// Bench for the cold redundancy role control block
`include "cr_params.svh"
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin \
    miscompares++; \
    $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module cold_redundancy_role_control_tb;
    logic        pclk, presetn, psel, penable, pwrite, pready, slv, err;
    logic        pin, oe_n, pu, ok, flt, wrn, pg, mon, frep, wrep;
    logic        sto, sto_o, stb, p_flt, p_m, line;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [15:0] shr, smp;
    logic [15:0] thr [6];
    int          miscompares, n_tests;

    cold_redundancy_role_control #(.PRE_WARN_CYCLES(50)) i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(slv),
        .dual_function_pin_in(line), .dual_function_pin_out(pin),
        .dual_function_pin_oe_n(oe_n), .redundancy_bus_pullup_en(pu),
        .input_power_ok(ok), .fault_in(flt), .warning_in(wrn),
        .current_share_bus(shr), .stored_rapid_bus_mode(sto),
        .stored_mode_out(sto_o), .power_good(pg), .main_output_on(mon),
        .fault_report(frep), .warning_report(wrep),
        .sample_strobe(stb), .input_power_sample(smp));
    cr_peer_unit i_peer (.pclk(pclk), .fault_req(p_flt),
        .master_req(p_m), .dut_out(pin), .dut_oe_n(oe_n),
        .dut_pullup(pu), .line(line));

    // Counts, verdict, end of run
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // One APB transfer, bounded wait for pready
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata} <= {1'h1, w, a, d};
        n = 0;
        @(posedge pclk);
        penable <= 1'h1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'h1 && n < 16);
        if (n >= 16) begin
            miscompares++;
            give_verdict;
        end
        q = prdata;
        err = slv;
        {psel, penable} <= 2'h0;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // Clock
    initial begin
        pclk = 1'h0;
        forever #4 pclk = ~pclk;
    end

    // Test sequence
    initial begin
        {presetn, psel, penable, pwrite, flt, wrn, sto, stb} = 8'h00;
        {p_flt, p_m, paddr, pwdata, shr} = 62'h0;
        {ok, smp} = 17'h10010;
        thr = '{`THR_ON_1, `THR_OFF_1, `THR_ON_2, `THR_OFF_2,
                `THR_ON_3, `THR_OFF_3};
        tick(8);
        presetn <= 1'h1;
        tick(6);
        `CHK("pin", 1'h1, pin)
        apb(1'h0, `REG_PIN_CMD, 32'h0);
        `CHK("mode", 1'h0, q[0])
        apb(1'h1, `REG_PIN_CMD, 32'h00EA6969);
        apb(1'h0, `REG_PIN_CMD, 32'h0);
        `CHK("mode", 1'h0, q[0])
        apb(1'h1, `REG_PIN_CMD, 32'h00EA9669);
        apb(1'h0, `REG_PIN_CMD, 32'h0);
        `CHK("mode", 1'h1, q[0])
        `CHK("store", 1'h1, sto_o)
        apb(1'h0, 12'h020, 32'h0);
        `CHK("slverr", 1'h1, err)
        $display("pin mode test done");
        p_m <= 1'h1;
        tick(4); // Let the pulled-up line pass the pin synchroniser
        for (int l = 0; l < 3; l++) begin
            shr <= 16'h0;
            apb(1'h1, `REG_ROLE, 32'(l + 2));
            {wrn, stb} <= 2'h3;
            tick(1);
            stb <= 1'h0;
            tick(3);
            `CHK("off", 1'h0, mon)
            `CHK("pg", 1'h1, pg)
            `CHK("wrep", 1'h0, wrep)
            `CHK("line", 1'h1, line)
            wrn <= 1'h0;
            apb(1'h1, `REG_ROLE, 32'h0);
            apb(1'h0, `REG_ROLE, 32'h0);
            `CHK("role", 3'(l + 2), q[2:0])
            for (int k = 0; k < 4; k++) begin
                shr <= thr[2 * l + k / 2] - 16'(k == 0 || k == 3);
                tick(4);
                `CHK("share", 1'(k == 1 || k == 2), mon)
            end
            p_flt <= 1'h1;
            tick(6);
            `CHK("rapid", 1'h1, mon)
            p_flt <= 1'h0;
            tick(4);
        end
        apb(1'h0, `REG_ENERGY_CNT, 32'h0);
        `CHK("count", 32'h3, q)
        apb(1'h0, `REG_ENERGY_ACC, 32'h0);
        `CHK("acc", 32'h30, q)
        $display("standby level test done");
        apb(1'h1, `REG_ROLE, 32'h5);
        apb(1'h0, `REG_ROLE, 32'h0);
        `CHK("role", 3'h4, q[2:0])
        apb(1'h1, `REG_ROLE, 32'h1);
        tick(2);
        `CHK("pullup", 1'h1, pu)
        p_flt <= 1'h1;
        tick(6);
        p_flt <= 1'h0;
        apb(1'h1, `REG_ROLE, 32'h0);
        flt <= 1'h1;
        tick(2);
        `CHK("pullup", 1'h0, pu)
        `CHK("line", 1'h0, line)
        `CHK("frep", 1'h1, frep)
        flt <= 1'h0;
        apb(1'h1, `REG_PIN_CMD, 32'h00EA6996);
        apb(1'h0, `REG_PIN_CMD, 32'h0);
        `CHK("mode", 1'h0, q[0])
        $display("role test done");
        ok <= 1'h0;
        tick(4);
        `CHK("pin", 1'h0, pin)
        tick(48);
        `CHK("pg", 1'h1, pg)
        tick(4);
        `CHK("pg", 1'h0, pg)
        $display("input loss test done");
        sto <= 1'h1;
        presetn <= 1'h0;
        tick(2);
        presetn <= 1'h1;
        tick(6);
        apb(1'h0, `REG_PIN_CMD, 32'h0);
        `CHK("mode", 1'h1, q[0])
        $display("stored mode test done");
        give_verdict;
    end
endmodule
`default_nettype wire

// >>> tb/cr_peer_unit.sv
// Peer supply unit sharing the redundancy bus line
`timescale 1ns/10ps
`default_nettype none
module cr_peer_unit (
    // Bench commands
    input  wire logic pclk,
    input  wire logic fault_req,
    input  wire logic master_req,
    // Device pin
    input  wire logic dut_out,
    input  wire logic dut_oe_n,
    input  wire logic dut_pullup,
    // Line level
    output logic      line
);
    logic low_ff;
    logic pullup_ff;
    // Peer pulls low on its fault, or acts as bus master
    always_ff @(posedge pclk) begin
        low_ff    <= fault_req;
        pullup_ff <= master_req;
    end
    // Wired low; released line falls to the pull-down
    assign line = (low_ff || (!dut_oe_n && !dut_out)) ? 1'h0 :
                  (!dut_oe_n || dut_pullup || pullup_ff);
endmodule
`default_nettype wire
